// ---- rtl/icon_supply_regs.vh ----
// Purpose: Command codes, field positions, reset values and counts for the
//          icon and supply command decoder.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef ICON_SUPPLY_REGS_VH
`define ICON_SUPPLY_REGS_VH

// Register select values of the two command groups.
`define RS_DISPLAY_GROUP 2'h2
`define RS_SUPPLY_GROUP 2'h3

// Icon setup command: fixed upper six bits and its two flags.
`define ICON_SETUP_CODE 6'h02
`define ICON_ONLY_BIT 1
`define ICON_BLINK_BIT 0

// Pump control command: fixed upper five bits, enable and multiplier field.
`define PUMP_CTRL_CODE 5'h10
`define PUMP_ENABLE_BIT 2
`define MULT_MSB 1
`define MULT_LSB 0
`define MULT_DOUBLE 2'h0
`define MULT_TRIPLE 2'h1
`define MULT_QUAD 2'h2
`define MULT_DIRECT 2'h3

// Voltage code commands: fixed prefixes of the high and low halves.
`define CHAR_HIGH_PREFIX 3'h5
`define CHAR_LOW_PREFIX 4'h9
`define ICON_HIGH_PREFIX 3'h6
`define ICON_LOW_PREFIX 4'hE

// Voltage code width and reset values of all settings.
`define VCODE_WIDTH 9
`define VCODE_RESET 9'h000
`define FLAG_RESET 1'h0
`define MULT_RESET 2'h0

// Icon memory layout: even phase from 00h, odd phase from 28h, 40 words.
`define ICON_EVEN_BASE 7'h00
`define ICON_ODD_BASE 7'h28
`define ICON_LAST_INDEX 6'h27
`define ICON_ADDR_WIDTH 7
`define ICON_INDEX_WIDTH 6

// Multiplex ratios reported to the waveform logic.
`define MUX_TWO_LINE 5'h12
`define MUX_ONE_LINE 5'h09
`define MUX_ICON_ONLY 5'h02

`endif

// ---- rtl/level_sync.v ----
// Purpose: Two flip-flop synchroniser for one level from another domain.
// Assumes: Destination clock is ref_clk; reset is synchronous, active high.
// Notes:   Only the second stage may be read by logic.
`default_nettype none

module level_sync (
  // Clock and reset.
  input wire ref_clk,
  input wire reset,
  // Asynchronous level in, synchronised level out.
  input wire async_in,
  output reg sync_out
);

  reg stage1_ff;

  // The first stage feeds the second stage only.
  always @(posedge ref_clk) begin
    if (reset) begin
      stage1_ff <= 1'h0;
      sync_out <= 1'h0;
    end else begin
      stage1_ff <= async_in;
      sync_out <= stage1_ff;
    end
  end

endmodule // level_sync

`default_nettype wire

// ---- rtl/icon_bit_memory.v ----
// Purpose: Icon state memory, one bit per word, even and odd phase halves.
// Assumes: Single clock; one write port and one read port.
// Notes:   Read data come out of a register one cycle after the address.
`default_nettype none

module icon_bit_memory #(
  parameter ADDR_WIDTH = 7,
  parameter DEPTH = 80
) (
  // Clock.
  input wire ref_clk,
  // Write port.
  input wire wr_en,
  input wire [ADDR_WIDTH-1:0] wr_addr,
  input wire wr_bit,
  // Read port.
  input wire [ADDR_WIDTH-1:0] rd_addr,
  output reg rd_bit
);

  reg mem [0:DEPTH-1];

  // Write and registered read; out-of-range writes are dropped.
  always @(posedge ref_clk) begin
    if (wr_en && (wr_addr < DEPTH)) begin
      mem[wr_addr] <= wr_bit;
    end
    rd_bit <= mem[rd_addr];
  end

endmodule // icon_bit_memory

`default_nettype wire

// ---- rtl/icon_and_supply_command_decoder.v ----
// Purpose: Decodes icon setup, charge pump and supply voltage command bytes,
//          holds the settings and scans icon states for the drivers.
// Assumes: Command bytes arrive as one-cycle strobes from the host bus layer
//          on ref_clk; the cursor blink phase arrives from another domain.
// Notes:   Analogue generation and waveform timing live elsewhere.
`default_nettype none
`include "icon_supply_regs.vh"

module icon_and_supply_command_decoder #(
  parameter ICON_COUNT = 40,
  parameter ICON_DEPTH = 80
) (
  // Clock and reset.
  input wire ref_clk,
  input wire reset,
  // Initialize command from the general command decoder, one-cycle pulse.
  input wire init_pulse,
  // Command byte strobe from the host bus layer.
  input wire cmd_valid,
  input wire cmd_read,
  input wire [1:0] register_select,
  input wire [7:0] cmd_data,
  // Icon memory write port from the memory access logic.
  input wire icon_wr_en,
  input wire [`ICON_ADDR_WIDTH-1:0] icon_wr_addr,
  input wire icon_wr_bit,
  // Display format and cursor blink phase.
  input wire two_line_mode,
  input wire cursor_blink_phase,
  // Settings towards display and supply logic.
  output reg icon_only_select,
  output reg icon_blink_enable,
  output reg pump_enable,
  output reg [1:0] multiplier_select,
  output reg [`VCODE_WIDTH-1:0] char_mode_voltage_code,
  output reg [`VCODE_WIDTH-1:0] icon_mode_voltage_code,
  output reg [`VCODE_WIDTH-1:0] lcd_supply_output,
  output reg [4:0] mux_ratio,
  output reg chars_driven,
  // Icon state scan towards the icon drivers.
  output reg [`ICON_INDEX_WIDTH-1:0] icon_index,
  output reg icon_state,
  output reg icon_state_valid,
  output reg odd_phase_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Replace the upper five bits of a voltage code, keeping the lower four.
  function [`VCODE_WIDTH-1:0] merge_high;
    input [`VCODE_WIDTH-1:0] code;
    input [4:0] bits;
    begin
      merge_high = {bits, code[3:0]};
    end
  endfunction

  // Replace the lower four bits of a voltage code, keeping the upper five.
  function [`VCODE_WIDTH-1:0] merge_low;
    input [`VCODE_WIDTH-1:0] code;
    input [3:0] bits;
    begin
      merge_low = {code[8:4], bits};
    end
  endfunction

  // Icon memory address of an icon in the chosen phase.
  function [`ICON_ADDR_WIDTH-1:0] icon_address;
    input [`ICON_INDEX_WIDTH-1:0] index;
    input odd;
    begin
      if (odd) begin
        icon_address = `ICON_ODD_BASE + {1'h0, index};
      end else begin
        icon_address = `ICON_EVEN_BASE + {1'h0, index};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.

  wire write_cmd;
  wire display_write;
  wire supply_write;
  wire hit_icon_setup;
  wire hit_pump;
  wire hit_char_high;
  wire hit_char_low;
  wire hit_icon_high;
  wire hit_icon_low;

  // Only writes are commands; reads of these settings are not decoded here.
  assign write_cmd = cmd_valid && !cmd_read;
  assign display_write = write_cmd && (register_select == `RS_DISPLAY_GROUP);
  assign supply_write = write_cmd && (register_select == `RS_SUPPLY_GROUP);
  assign hit_icon_setup = display_write && (cmd_data[7:2] == `ICON_SETUP_CODE);
  assign hit_pump = supply_write && (cmd_data[7:3] == `PUMP_CTRL_CODE);
  assign hit_char_high = supply_write && (cmd_data[7:5] == `CHAR_HIGH_PREFIX);
  assign hit_char_low = supply_write && (cmd_data[7:4] == `CHAR_LOW_PREFIX);
  assign hit_icon_high = supply_write && (cmd_data[7:5] == `ICON_HIGH_PREFIX);
  assign hit_icon_low = supply_write && (cmd_data[7:4] == `ICON_LOW_PREFIX);

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers.

  reg icon_only_ff;
  reg blink_enable_ff;
  reg pump_enable_ff;
  reg [1:0] mult_ff;
  reg [`VCODE_WIDTH-1:0] char_code_ff;
  reg [`VCODE_WIDTH-1:0] icon_code_ff;
  reg [`VCODE_WIDTH-1:0] nxt_char_code;
  reg [`VCODE_WIDTH-1:0] nxt_icon_code;

  // Next voltage codes; a half write touches only its own bits.
  always @* begin
    nxt_char_code = char_code_ff;
    nxt_icon_code = icon_code_ff;
    if (hit_char_high) begin
      nxt_char_code = merge_high(char_code_ff, cmd_data[4:0]);
    end else if (hit_char_low) begin
      nxt_char_code = merge_low(char_code_ff, cmd_data[3:0]);
    end
    if (hit_icon_high) begin
      nxt_icon_code = merge_high(icon_code_ff, cmd_data[4:0]);
    end else if (hit_icon_low) begin
      nxt_icon_code = merge_low(icon_code_ff, cmd_data[3:0]);
    end
  end

  // Settings load on their commands and clear on reset or initialize.
  always @(posedge ref_clk) begin
    if (reset || init_pulse) begin
      icon_only_ff <= `FLAG_RESET;
      blink_enable_ff <= `FLAG_RESET;
      pump_enable_ff <= `FLAG_RESET;
      mult_ff <= `MULT_RESET;
      char_code_ff <= `VCODE_RESET;
      icon_code_ff <= `VCODE_RESET;
    end else begin
      if (hit_icon_setup) begin
        icon_only_ff <= cmd_data[`ICON_ONLY_BIT];
        blink_enable_ff <= cmd_data[`ICON_BLINK_BIT];
      end
      if (hit_pump) begin
        pump_enable_ff <= cmd_data[`PUMP_ENABLE_BIT];
        mult_ff <= cmd_data[`MULT_MSB:`MULT_LSB];
      end
      char_code_ff <= nxt_char_code;
      icon_code_ff <= nxt_icon_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode-dependent outputs.

  reg [`VCODE_WIDTH-1:0] nxt_supply;
  reg [4:0] nxt_ratio;

  // Icon-only mode picks the 1:2 ratio and the icon voltage code.
  always @* begin
    if (icon_only_ff) begin
      nxt_supply = icon_code_ff;
      nxt_ratio = `MUX_ICON_ONLY;
    end else begin
      nxt_supply = char_code_ff;
      nxt_ratio = two_line_mode ? `MUX_TWO_LINE : `MUX_ONE_LINE;
    end
  end

  // All settings leave the block through flip-flops.
  always @(posedge ref_clk) begin
    if (reset) begin
      icon_only_select <= `FLAG_RESET;
      icon_blink_enable <= `FLAG_RESET;
      pump_enable <= `FLAG_RESET;
      multiplier_select <= `MULT_RESET;
      char_mode_voltage_code <= `VCODE_RESET;
      icon_mode_voltage_code <= `VCODE_RESET;
      lcd_supply_output <= `VCODE_RESET;
      mux_ratio <= `MUX_ONE_LINE;
      chars_driven <= 1'h1;
    end else begin
      icon_only_select <= icon_only_ff;
      icon_blink_enable <= blink_enable_ff;
      pump_enable <= pump_enable_ff;
      multiplier_select <= mult_ff;
      char_mode_voltage_code <= char_code_ff;
      icon_mode_voltage_code <= icon_code_ff;
      lcd_supply_output <= nxt_supply;
      mux_ratio <= nxt_ratio;
      chars_driven <= !icon_only_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink phase: cursor blink level comes from the oscillator domain.

  wire blink_phase_sync;
  reg blink_phase_last_ff;
  wire phase_edge;

  level_sync u_phase_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(cursor_blink_phase),
    .sync_out(blink_phase_sync)
  );

  // A phase change restarts the scan; an icon blink enable change does not, so a sweep can then mix two phases.
  always @(posedge ref_clk) begin
    if (reset) begin
      blink_phase_last_ff <= 1'h0;
    end else begin
      blink_phase_last_ff <= blink_phase_sync;
    end
  end

  assign phase_edge = blink_phase_sync != blink_phase_last_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Icon scan: read each icon's bit for the current phase, one every two cycles.

  localparam SCAN_READ = 1'b0;
  localparam SCAN_LATCH = 1'b1;

  reg scan_state_ff;
  reg [`ICON_INDEX_WIDTH-1:0] scan_index_ff;
  reg scan_odd_ff;
  wire [`ICON_ADDR_WIDTH-1:0] scan_addr;
  wire use_odd;
  wire mem_bit;

  // Odd half of the cursor blink selects odd bits only while blinking.
  assign use_odd = blink_enable_ff && blink_phase_sync;

  // The address reaches the memory unregistered, so the bit read on the READ edge
  // is the one latched on the LATCH edge; a registered address would add a cycle
  // and hand over the bit of the previous icon instead.
  assign scan_addr = icon_address(scan_index_ff, use_odd);

  icon_bit_memory #(
    .ADDR_WIDTH(`ICON_ADDR_WIDTH),
    .DEPTH(ICON_DEPTH)
  ) u_icon_mem (
    .ref_clk(ref_clk),
    .wr_en(icon_wr_en),
    .wr_addr(icon_wr_addr),
    .wr_bit(icon_wr_bit),
    .rd_addr(scan_addr),
    .rd_bit(mem_bit)
  );

  // Scan state machine: issue address, then latch the registered bit.
  always @(posedge ref_clk) begin
    if (reset || phase_edge) begin
      scan_state_ff <= SCAN_READ;
      scan_index_ff <= {`ICON_INDEX_WIDTH{1'b0}};
      scan_odd_ff <= 1'h0;
      icon_index <= {`ICON_INDEX_WIDTH{1'b0}};
      icon_state <= 1'h0;
      icon_state_valid <= 1'h0;
      odd_phase_active <= 1'h0;
    end else begin
      case (scan_state_ff)
        SCAN_READ: begin
          scan_odd_ff <= use_odd;
          icon_state_valid <= 1'h0;
          scan_state_ff <= SCAN_LATCH;
        end
        SCAN_LATCH: begin
          icon_index <= scan_index_ff;
          icon_state <= mem_bit;
          icon_state_valid <= 1'h1;
          odd_phase_active <= scan_odd_ff;
          if (scan_index_ff == `ICON_LAST_INDEX) begin
            scan_index_ff <= {`ICON_INDEX_WIDTH{1'b0}};
          end else begin
            scan_index_ff <= scan_index_ff + 1'b1;
          end
          scan_state_ff <= SCAN_READ;
        end
        default: begin
          scan_state_ff <= SCAN_READ;
        end
      endcase
    end
  end

endmodule // icon_and_supply_command_decoder

`default_nettype wire

// ---- verification/icon_supply_checker.sv ----
// Purpose: Port assertions for the icon and supply command decoder.
// Assumes: Bound to every decoder instance; settings show two edges after a command.
// Notes: Commands in the same cycle as init_pulse are not judged.
`default_nettype none
`include "icon_supply_regs.vh"

module icon_supply_checker (
  // Clock, reset, command bus and display format.
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic init_pulse,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [1:0] register_select,
  input wire logic [7:0] cmd_data,
  input wire logic two_line_mode,
  // Settings and scan.
  input wire logic icon_only_select,
  input wire logic icon_blink_enable,
  input wire logic pump_enable,
  input wire logic [1:0] multiplier_select,
  input wire logic [`VCODE_WIDTH-1:0] char_mode_voltage_code,
  input wire logic [`VCODE_WIDTH-1:0] icon_mode_voltage_code,
  input wire logic [`VCODE_WIDTH-1:0] lcd_supply_output,
  input wire logic [4:0] mux_ratio,
  input wire logic chars_driven,
  input wire logic icon_state_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Decoded write strobes of the two command groups.
  wire logic wr = cmd_valid && !cmd_read && !init_pulse;
  wire logic dsp = wr && register_select == `RS_DISPLAY_GROUP;
  wire logic sup = wr && register_select == `RS_SUPPLY_GROUP;

  ////////////////////////////////////////////////////////////////////////////
  a_icon_setup_load: assert property (dsp && cmd_data[7:2] == `ICON_SETUP_CODE
    |-> ##2 {icon_only_select, icon_blink_enable} == $past(cmd_data[1:0], 2))
    else $error("icon setup flags not applied");
  a_pump_ctrl_load: assert property (sup && cmd_data[7:3] == `PUMP_CTRL_CODE
    |-> ##2 {pump_enable, multiplier_select} == $past(cmd_data[2:0], 2))
    else $error("pump setting not applied");
  a_char_high_half: assert property (sup && cmd_data[7:5] == `CHAR_HIGH_PREFIX
    |-> ##2 char_mode_voltage_code[8:4] == $past(cmd_data[4:0], 2)
    && $stable(char_mode_voltage_code[3:0])) else $error("char high half wrong");
  a_char_low_half: assert property (sup && cmd_data[7:4] == `CHAR_LOW_PREFIX
    |-> ##2 char_mode_voltage_code[3:0] == $past(cmd_data[3:0], 2)
    && $stable(char_mode_voltage_code[8:4])) else $error("char low half wrong");
  a_icon_high_half: assert property (sup && cmd_data[7:5] == `ICON_HIGH_PREFIX
    |-> ##2 icon_mode_voltage_code[8:4] == $past(cmd_data[4:0], 2)
    && $stable(icon_mode_voltage_code[3:0])) else $error("icon high half wrong");
  a_icon_low_half: assert property (sup && cmd_data[7:4] == `ICON_LOW_PREFIX
    |-> ##2 icon_mode_voltage_code[3:0] == $past(cmd_data[3:0], 2)
    && $stable(icon_mode_voltage_code[8:4])) else $error("icon low half wrong");
  a_char_mode_mux: assert property (!icon_only_select
    |-> chars_driven && mux_ratio == ($past(two_line_mode) ? `MUX_TWO_LINE : `MUX_ONE_LINE))
    else $error("character mode ratio wrong");
  a_supply_code_pick: assert property (lcd_supply_output ==
    (icon_only_select ? icon_mode_voltage_code : char_mode_voltage_code))
    else $error("supply code from wrong mode");
  a_icon_only_mux: assert property (icon_only_select
    |-> mux_ratio == `MUX_ICON_ONLY && !chars_driven) else $error("icon mode ratio wrong");
  a_scan_pulse_gap: assert property (icon_state_valid |=> !icon_state_valid)
    else $error("scan pulses too close");
endmodule // icon_supply_checker

bind icon_and_supply_command_decoder icon_supply_checker icon_supply_checker_inst (
  .ref_clk, .reset, .init_pulse, .cmd_valid, .cmd_read, .register_select, .cmd_data,
  .icon_only_select, .icon_blink_enable, .pump_enable, .multiplier_select,
  .char_mode_voltage_code, .icon_mode_voltage_code, .lcd_supply_output, .mux_ratio,
  .chars_driven, .icon_state_valid, .two_line_mode);
`default_nettype wire

// ---- verification/host_cmd_model.sv ----
// Purpose: Host side model that writes command bytes to the decoder.
// Assumes: One byte per edge; callers chain sends back to back.
// Notes: A released bus shows the inverse of its last byte.
`default_nettype none
`include "icon_supply_regs.vh"

module host_cmd_model (
  // Clock.
  input wire logic ref_clk,
  // Command byte strobe.
  output var logic cmd_valid,
  output var logic cmd_read,
  output var logic [1:0] register_select,
  output var logic [7:0] cmd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idles with no strobe.
  initial begin
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    register_select = 2'h0;
    cmd_data = 8'h00;
  end

  // Drives one byte for one edge.
  task automatic send(input logic rd, input logic [1:0] rs, input logic [7:0] d);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    register_select <= rs;
    cmd_data <= d;
  endtask

  // Releases the bus so stale data cannot pass for a command.
  task automatic idle();
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    register_select <= ~register_select;
    cmd_data <= ~cmd_data;
  endtask

  task automatic icon_setup(input logic im, input logic ib);
    send(1'b0, `RS_DISPLAY_GROUP, {`ICON_SETUP_CODE, im, ib});
  endtask

  task automatic pump(input logic en, input logic [1:0] m);
    send(1'b0, `RS_SUPPLY_GROUP, {`PUMP_CTRL_CODE, en, m});
  endtask

  // Sends both halves of a voltage code in the chosen order.
  task automatic vcode(input logic icon, input logic hi_first, input logic [8:0] v);
    logic [7:0] hb;
    logic [7:0] lb;
    hb = {icon ? `ICON_HIGH_PREFIX : `CHAR_HIGH_PREFIX, v[8:4]};
    lb = {icon ? `ICON_LOW_PREFIX : `CHAR_LOW_PREFIX, v[3:0]};
    send(1'b0, `RS_SUPPLY_GROUP, hi_first ? hb : lb);
    send(1'b0, `RS_SUPPLY_GROUP, hi_first ? lb : hb);
  endtask
endmodule // host_cmd_model
`default_nettype wire

// ---- verification/icon_and_supply_command_decoder_tb.sv ----
// Purpose: Self-checking bench of the icon and supply command decoder.
// Assumes: Host model drives the command bus; the bench drives the rest.
// Notes: Scan states are checked against a pattern written into icon memory.
`default_nettype none
`include "icon_supply_regs.vh"
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module icon_and_supply_command_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset, init_pulse, cmd_valid, cmd_read, icon_wr_en, icon_wr_bit;
  logic two_line_mode, cursor_blink_phase, blink_run, mon_on;
  logic icon_only_select, icon_blink_enable, pump_enable, chars_driven;
  logic icon_state, icon_state_valid, odd_phase_active;
  logic [1:0] register_select, multiplier_select;
  logic [7:0] cmd_data;
  logic [6:0] icon_wr_addr;
  logic [8:0] char_mode_voltage_code, icon_mode_voltage_code, lcd_supply_output;
  logic [4:0] mux_ratio;
  logic [5:0] icon_index;
  int bad_count, checks, cycles, odd_seen, even_seen;

  icon_and_supply_command_decoder icon_and_supply_command_decoder_inst (
    .ref_clk, .reset, .init_pulse, .cmd_valid, .cmd_read, .register_select, .cmd_data,
    .icon_wr_en, .icon_wr_addr, .icon_wr_bit, .two_line_mode, .cursor_blink_phase,
    .icon_only_select, .icon_blink_enable, .pump_enable, .multiplier_select,
    .char_mode_voltage_code, .icon_mode_voltage_code, .lcd_supply_output, .mux_ratio,
    .chars_driven, .icon_index, .icon_state, .icon_state_valid, .odd_phase_active);
  host_cmd_model host (.ref_clk, .cmd_valid, .cmd_read, .register_select, .cmd_data);

  function automatic logic pat(input logic [6:0] a);
    return a[0] ^ a[2] ^ a[4];
  endfunction

  task automatic finish_test();
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic settle();
    host.idle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, cursor blink phase off the clock grid, and hang limit.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    cursor_blink_phase = 1'b0;
    #1.3;
    forever begin
      #62.5;
      if (blink_run) cursor_blink_phase = ~cursor_blink_phase;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // Scan monitor: odd phase reads the inverted half of memory.
  always @(posedge ref_clk) begin
    if (mon_on && icon_state_valid === 1'b1) begin
      `CHECK(icon_state, odd_phase_active ^ pat({1'b0, icon_index}))
      `CHECK(odd_phase_active && !icon_blink_enable, 1'b0)
      if (odd_phase_active) odd_seen++;
      else even_seen++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    init_pulse = 1'b0;
    icon_wr_en = 1'b0;
    icon_wr_addr = 7'h00;
    icon_wr_bit = 1'b0;
    two_line_mode = 1'b0;
    blink_run = 1'b0;
    mon_on = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a < 80; a++) begin
      @(posedge ref_clk);
      icon_wr_en <= 1'b1;
      icon_wr_addr <= 7'(a);
      icon_wr_bit <= (a < 40) ? pat(7'(a)) : ~pat(7'(a - 40));
    end
    @(posedge ref_clk);
    icon_wr_en <= 1'b0;
    #1;
    `CHECK({icon_only_select, icon_blink_enable, pump_enable, multiplier_select}, 5'h00)
    `CHECK({char_mode_voltage_code, icon_mode_voltage_code}, 18'h00000)
    `CHECK({mux_ratio, chars_driven}, {`MUX_ONE_LINE, 1'b1})
    for (int m = 0; m < 4; m++) begin
      host.pump(m[0], 2'(m));
      settle();
      `CHECK({pump_enable, multiplier_select}, {m[0], 2'(m)})
    end
    // Wrong group, a read, and an unrelated supply byte are all ignored.
    host.send(1'b0, `RS_DISPLAY_GROUP, 8'h87);
    host.send(1'b1, `RS_DISPLAY_GROUP, 8'h0B);
    host.send(1'b0, `RS_SUPPLY_GROUP, 8'h07);
    settle();
    `CHECK({icon_only_select, icon_blink_enable, pump_enable, multiplier_select}, 5'h07)
    host.vcode(1'b0, 1'b0, 9'h1A5);
    host.vcode(1'b1, 1'b1, 9'h0C3);
    settle();
    `CHECK({char_mode_voltage_code, lcd_supply_output}, {9'h1A5, 9'h1A5})
    `CHECK(icon_mode_voltage_code, 9'h0C3)
    host.send(1'b0, `RS_SUPPLY_GROUP, {`CHAR_LOW_PREFIX, 4'h6});
    host.send(1'b0, `RS_SUPPLY_GROUP, {`ICON_HIGH_PREFIX, 5'h1F});
    settle();
    `CHECK({char_mode_voltage_code, icon_mode_voltage_code}, {9'h1A6, 9'h1F3})
    host.icon_setup(1'b1, 1'b0);
    settle();
    `CHECK({lcd_supply_output, mux_ratio, chars_driven}, {9'h1F3, `MUX_ICON_ONLY, 1'b0})
    @(posedge ref_clk);
    two_line_mode <= 1'b1;
    host.icon_setup(1'b0, 1'b0);
    settle();
    `CHECK({lcd_supply_output, mux_ratio, chars_driven}, {9'h1A6, `MUX_TWO_LINE, 1'b1})
    // Cursor phase runs while icon blink is off, then with it on.
    blink_run = 1'b1;
    mon_on = 1'b1;
    repeat (400) @(posedge ref_clk);
    `CHECK({icon_blink_enable, odd_seen == 0}, 2'b01)
    mon_on = 1'b0;
    host.icon_setup(1'b0, 1'b1);
    settle();
    repeat (10) @(posedge ref_clk);
    mon_on = 1'b1;
    repeat (800) @(posedge ref_clk);
    `CHECK({odd_seen > 0, even_seen > 0}, 2'b11)
    mon_on = 1'b0;
    @(posedge ref_clk);
    init_pulse <= 1'b1;
    @(posedge ref_clk);
    init_pulse <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHECK({icon_only_select, icon_blink_enable, pump_enable, multiplier_select}, 5'h00)
    finish_test();
  end
endmodule // icon_and_supply_command_decoder_tb
`default_nettype wire
